// ### src/cme_event_regs.v
/*
  Event register block of the clock module: raw and masked status, mask,
  write-one set/clear registers, identification and oscillator controls,
  reached over APB.
  Assumes event inputs are one-cycle or level pulses synchronous to clk and
  that the slow clocks are already brought into the clk domain.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "cme_defines.vh"
module cme_event_regs #(
  parameter [31:0] IDENT_VALUE = 32'h12340000, // Arbitrary identification value
  parameter LOSS_CYC = `CME_LOSS_CYC,
  parameter TICK_CYC = `CME_TICK_CYC
) (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire slowClk,
  input wire candClk,
  input wire [2:0] ampState,
  input wire cap1AtTarget,
  input wire cap2AtTarget,
  input wire currentAtTarget,
  input wire periodOutOfRange,
  input wire qualified,
  input wire incrementStored,
  input wire gearingRestart,
  input wire converterDone,
  input wire adcPeakDone,
  input wire adcBiasDone,
  input wire adcCompareDone,
  output reg slowTick,
  output reg slowClockLost,
  output reg irq,
  output reg [31:0] fastOscCtl,
  output reg [31:0] fastXtalCtl,
  output reg [31:0] slowOscCtl,
  output reg [31:0] slowXtalCtl
);
  // Amplitude state codes seen on ampState
  localparam [2:0] AMP_SETTLED = 3'h4;
  localparam [2:0] AMP_EXTOSC = 3'h5;

  reg rstSync1;
  reg rstSync2;
  wire rst2n;
  reg [`CME_EV_W-1:0] rawEv;
  reg [`CME_EV_W-1:0] maskEv;
  reg [`CME_EV_W-1:0] next_rawEv;
  reg [`CME_EV_W-1:0] next_maskEv;
  reg [`CME_EV_W-1:0] hwEv;
  reg [31:0] next_prdata;
  reg mapped;
  wire tickPulse;
  wire lossPulse;
  wire candEdge;
  wire lostLvl;
  wire atTarget;
  wire wrStrobe;
  wire [`CME_EV_W-1:0] wrBits;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rst2n = rstSync2;

  cme_tick_gen #(
    .LOSS_CYC(LOSS_CYC),
    .TICK_CYC(TICK_CYC)
  ) uTick (
    .clk(clk),
    .rstn(rst2n),
    .slowClk(slowClk),
    .candClk(candClk),
    .tick(tickPulse),
    .lossPulse(lossPulse),
    .candEdge(candEdge),
    .lost(lostLvl)
  );

  assign atTarget = cap1AtTarget & cap2AtTarget & currentAtTarget;  // [R14]

  // Hardware event sources, indexed from the lowest event bit
  always @* begin
    hwEv = {`CME_EV_W{1'b0}};
    hwEv[`CME_BIT_TICK-`CME_EV_LSB] = tickPulse;  // [R9]
    hwEv[`CME_BIT_GEAR-`CME_EV_LSB] = gearingRestart;  // [R17]
    hwEv[`CME_BIT_AMPSET-`CME_EV_LSB] = atTarget &
      (ampState == AMP_SETTLED || ampState == AMP_EXTOSC);  // [R13]
    hwEv[`CME_BIT_ATTARG-`CME_EV_LSB] = atTarget;  // [R14]
    hwEv[`CME_BIT_CANDEDGE-`CME_EV_LSB] = candEdge;  // [R12]
    hwEv[`CME_BIT_LOSS-`CME_EV_LSB] = lossPulse;  // [R10]
    hwEv[`CME_BIT_OOR-`CME_EV_LSB] = periodOutOfRange;  // [R15]
    hwEv[`CME_BIT_GOOD-`CME_EV_LSB] = qualified;  // [R15]
    hwEv[`CME_BIT_INCUPD-`CME_EV_LSB] = incrementStored;  // [R16]
    hwEv[`CME_BIT_TDC-`CME_EV_LSB] = converterDone;  // [R18]
    hwEv[`CME_BIT_PEAK-`CME_EV_LSB] = adcPeakDone;  // [R18]
    hwEv[`CME_BIT_BIAS-`CME_EV_LSB] = adcBiasDone;  // [R18]
    hwEv[`CME_BIT_COMP-`CME_EV_LSB] = adcCompareDone;  // [R18]
  end

  // Zero-wait APB: a write lands on the access-phase edge
  assign wrStrobe = psel & penable & pwrite;
  assign wrBits = pwdata[`CME_EV_MSB:`CME_EV_LSB];

  // Event and mask next state; clear first so a same-cycle set wins
  always @* begin
    next_rawEv = rawEv;
    next_maskEv = maskEv;
    if (wrStrobe && paddr == `CME_OFS_CLR) begin
      next_rawEv = next_rawEv & ~wrBits;  // [R4]
    end
    next_rawEv = next_rawEv | hwEv;
    if (wrStrobe && paddr == `CME_OFS_FSET) begin
      next_rawEv = next_rawEv | wrBits;  // [R5]
    end
    if (wrStrobe && paddr == `CME_OFS_MASK) begin
      next_maskEv = wrBits;
    end
    if (wrStrobe && paddr == `CME_OFS_MSET) begin
      next_maskEv = next_maskEv | wrBits;  // [R6]
    end
    if (wrStrobe && paddr == `CME_OFS_MCLR) begin
      next_maskEv = next_maskEv & ~wrBits;  // [R7]
    end
  end

  // Event state and derived interrupt, all cleared at reset
  always @(posedge clk or negedge rst2n) begin
    if (!rst2n) begin
      rawEv <= `CME_EV_RESET;  // [R8]
      maskEv <= `CME_EV_RESET;
      irq <= 1'b0;
      slowTick <= 1'b0;
      slowClockLost <= 1'b0;
    end else begin
      rawEv <= next_rawEv;
      maskEv <= next_maskEv;
      irq <= |(next_rawEv & next_maskEv);  // [R21]
      slowTick <= tickPulse;
      slowClockLost <= lostLvl;
    end
  end

  // Oscillator control registers, plain storage for the analog side
  always @(posedge clk or negedge rst2n) begin
    if (!rst2n) begin
      fastOscCtl <= `CME_CTL_RESET;
      fastXtalCtl <= `CME_CTL_RESET;
      slowOscCtl <= `CME_CTL_RESET;
      slowXtalCtl <= `CME_CTL_RESET;
    end else if (wrStrobe) begin
      if (paddr == `CME_OFS_FOSC) begin
        fastOscCtl <= pwdata;
      end
      if (paddr == `CME_OFS_FXT) begin
        fastXtalCtl <= pwdata;
      end
      if (paddr == `CME_OFS_SOSC) begin
        slowOscCtl <= pwdata;
      end
      if (paddr == `CME_OFS_SXT) begin
        slowXtalCtl <= pwdata;
      end
    end
  end

  // Read mux; write-only and unlisted words read zero
  always @* begin
    next_prdata = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `CME_OFS_IDENT: next_prdata = IDENT_VALUE;  // [R19]
      `CME_OFS_MASK: next_prdata[`CME_EV_MSB:`CME_EV_LSB] = maskEv;
      `CME_OFS_RAW: next_prdata[`CME_EV_MSB:`CME_EV_LSB] = rawEv;  // [R1] [R8]
      `CME_OFS_MASKED: next_prdata[`CME_EV_MSB:`CME_EV_LSB] = rawEv & maskEv;  // [R2] [R3]
      `CME_OFS_FSET: next_prdata = 32'h00000000;
      `CME_OFS_CLR: next_prdata = 32'h00000000;
      `CME_OFS_MSET: next_prdata = 32'h00000000;
      `CME_OFS_MCLR: next_prdata = 32'h00000000;
      `CME_OFS_FOSC: next_prdata = fastOscCtl;
      `CME_OFS_FXT: next_prdata = fastXtalCtl;
      `CME_OFS_SOSC: next_prdata = slowOscCtl;
      `CME_OFS_SXT: next_prdata = slowXtalCtl;
      default: mapped = 1'b0;  // [R20]
    endcase
  end

  // Registered answer: ready in the access phase, one cycle after setup
  always @(posedge clk or negedge rst2n) begin
    if (!rst2n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule

// ### src/cme_defines.vh
/*
  Constants for the clock-module event register block: register offsets,
  event bit positions, reset values and timing counts.
  Assumes a 125 MHz module clock and word-aligned APB byte addresses.
*/
// Overview of operation
// R1: Raw status shows every pending event flag regardless of its mask bit.
// R2: Each masked status bit is the AND of mask bit and raw bit.
// R3: Mask bit one passes its raw event to masked status; zero blocks it.
// R4: Writing one to clear register clears that raw event; zero does nothing.
// R5: Writing one to force-set register raises that raw event for diagnostics.
// R6: Writing one to mask-set register sets that mask bit; zeros leave it.
// R7: Writing one to mask-clear register clears that mask bit; zeros leave it.
// R8: Events occupy bits 17 to 5; bits 31 to 18 read zero; reset zero.
// R9: Slow tick follows selected slow clock, else generated from always-on clock.
// R10: Clock-loss event raised when no slow clock edge seen for about 49 us.
// R11: On slow clock loss, tick falls back to always-on clock; no reset caused.
// R12: Candidate clock edge event raised on each rising edge of candidate clock.
// R13: Amplitude-settled event raised in settled or external-oscillator state at target.
// R14: Controls-at-target event raised when both caps and current reach target.
// R15: Out-of-range event on period error beyond maximum; good event on qualification.
// R16: Increment-updated event raised when a new increment measurement is stored.
// R17: Gearing-restart event raised when the increment filter restarts gearing.
// R18: Converter done at bit 8; ADC peak, bias, compare at bits 7, 6, 5.
// R19: Identification register reports identifier, revisions, instance, offset; read-only.
// R20: Software must not modify unlisted offsets; they read zero here.
// R21: Interrupt output high while any masked status bit is set.
`ifndef CME_DEFINES_VH
`define CME_DEFINES_VH

`define CME_OFS_IDENT 12'h000
`define CME_OFS_MASK 12'h044
`define CME_OFS_RAW 12'h048
`define CME_OFS_MASKED 12'h04C
`define CME_OFS_FSET 12'h050
`define CME_OFS_CLR 12'h054
`define CME_OFS_MSET 12'h058
`define CME_OFS_MCLR 12'h05C
`define CME_OFS_FOSC 12'h080
`define CME_OFS_FXT 12'h084
`define CME_OFS_SOSC 12'h08C
`define CME_OFS_SXT 12'h090

// Event field
`define CME_EV_LSB 5
`define CME_EV_MSB 17
`define CME_EV_W 13
`define CME_BIT_TICK 17
`define CME_BIT_GEAR 16
`define CME_BIT_AMPSET 15
`define CME_BIT_ATTARG 14
`define CME_BIT_CANDEDGE 13
`define CME_BIT_LOSS 12
`define CME_BIT_OOR 11
`define CME_BIT_GOOD 10
`define CME_BIT_INCUPD 9
`define CME_BIT_TDC 8
`define CME_BIT_PEAK 7
`define CME_BIT_BIAS 6
`define CME_BIT_COMP 5
`define CME_EV_RESET 13'h0000
`define CME_CTL_RESET 32'h00000000

// Loss timeout: 49 us at 8 ns per cycle, rounded down
`define CME_LOSS_NS 49000
`define CME_CLK_NS 8
`define CME_LOSS_CYC (`CME_LOSS_NS / `CME_CLK_NS)
// Fallback tick period, nominal 32768 Hz: 30518 ns
`define CME_TICK_NS 30518
`define CME_TICK_CYC (`CME_TICK_NS / `CME_CLK_NS)

`endif

// ### src/cme_edge_detect.v
/*
  Rising edge detector for one synchronous level input.
  Assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ps
module cme_edge_detect (
  input wire clk,
  input wire rstn,
  input wire level,
  output wire rise
);
  reg last;

  // Previous sample, cleared at reset so a high level after reset counts
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule

// ### src/cme_tick_gen.v
/*
  Slow tick generator with clock-loss detection and fallback.
  Assumes slowClk and candClk are slow levels synchronous to clk.
*/
`timescale 1ns/1ps
`include "cme_defines.vh"
module cme_tick_gen #(
  parameter LOSS_CYC = `CME_LOSS_CYC,
  parameter TICK_CYC = `CME_TICK_CYC
) (
  input wire clk,
  input wire rstn,
  input wire slowClk,
  input wire candClk,
  output reg tick,
  output reg lossPulse,
  output wire candEdge,
  output reg lost
);
  wire slowEdge;
  reg [15:0] idleCnt;
  reg [15:0] fbCnt;

  cme_edge_detect uSlow (
    .clk(clk),
    .rstn(rstn),
    .level(slowClk),
    .rise(slowEdge)
  );

  cme_edge_detect uCand (
    .clk(clk),
    .rstn(rstn),
    .level(candClk),
    .rise(candEdge)  // [R12]
  );

  // Idle watch; a loss only flags and switches source, it never resets
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idleCnt <= 16'h0000;
      lost <= 1'b0;
      lossPulse <= 1'b0;
    end else begin
      lossPulse <= 1'b0;
      if (slowEdge) begin
        idleCnt <= 16'h0000;
        lost <= 1'b0;
      end else if (idleCnt == LOSS_CYC[15:0] - 16'h0001) begin
        if (!lost) begin
          lossPulse <= 1'b1;  // [R10]
        end
        lost <= 1'b1;  // [R11]
      end else begin
        idleCnt <= idleCnt + 16'h0001;
      end
    end
  end

  // Tick from slow clock edges, or from a local divider while lost
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fbCnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      if (!lost || fbCnt == TICK_CYC[15:0] - 16'h0001) begin
        fbCnt <= 16'h0000;
      end else begin
        fbCnt <= fbCnt + 16'h0001;
      end
      tick <= lost ? (fbCnt == TICK_CYC[15:0] - 16'h0001) : slowEdge;  // [R9] [R11]
    end
  end
endmodule

// ### tb/cme_event_regs_asserts.sv
/* Assertions for cme_event_regs, bound to its ports.
   Assumes the bench keeps APB transfer order. */
`timescale 1ns/1ps
module cme_event_regs_asserts #(
  parameter [31:0] IDENT_VALUE = 32'h12340000,
  parameter LOSS_CYC = 40,
  parameter TICK_CYC = 10
) (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire slowClk,
  input wire slowTick,
  input wire slowClockLost,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  reg prevClk;
  reg [15:0] quiet;
  reg [15:0] gap;
  wire ctl = paddr == 12'h080 || paddr == 12'h084 || paddr == 12'h08C || paddr == 12'h090;
  wire evr = paddr >= 12'h044 && paddr <= 12'h05C && paddr[1:0] == 2'h0;
  // Cycles since the slow clock moved, and since the last tick while lost
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevClk <= 1'b0;
      quiet <= 16'h0000;
      gap <= 16'h0000;
    end else begin
      prevClk <= slowClk;
      quiet <= (slowClk != prevClk) ? 16'h0000 : quiet + 16'h0001;
      gap <= (slowTick || !slowClockLost) ? 16'h0000 : gap + 16'h0001;
    end
  end
  sequence s_rd; psel && penable && pready && !pwrite; endsequence
  sequence s_wr; psel && penable && pready && pwrite; endsequence
  property p_err;
    psel && penable && pready |-> pslverr == !(ctl || evr || paddr == 12'h000);
  endproperty
  property p_id; (s_rd ##0 paddr == 12'h000) |-> prdata == IDENT_VALUE; endproperty
  property p_rsv; (s_rd ##0 evr) |-> prdata[31:18] == 14'h0000 && prdata[4:0] == 5'h00; endproperty
  property p_mclr; (s_wr ##0 paddr == 12'h05C && pwdata[17:5] == 13'h1FFF) |=> !irq; endproperty
  property p_mwr; (s_wr ##0 paddr == 12'h044 && pwdata[17:5] == 13'h0000) |=> !irq; endproperty
  property p_tick; $rose(slowClk) && !slowClockLost |-> ##[1:3] slowTick; endproperty
  property p_loss; quiet == LOSS_CYC + 6 |-> slowClockLost; endproperty
  // A lost slow clock must not stop the tick for longer than one fallback period
  property p_fall; slowClockLost |-> gap <= TICK_CYC + 3; endproperty
  a_err: assert property (p_err) else $error("slave error flag wrong");
  a_id: assert property (p_id) else $error("identification read wrong");
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  a_mclr: assert property (p_mclr) else $error("irq after full mask clear");
  a_mwr: assert property (p_mwr) else $error("irq with zero mask");
  a_tick: assert property (p_tick) else $error("no tick after slow edge");
  a_loss: assert property (p_loss) else $error("slow clock loss missed");
  a_fall: assert property (p_fall) else $error("fallback tick missing");
endmodule
bind cme_event_regs cme_event_regs_asserts #(
  .IDENT_VALUE(IDENT_VALUE), .LOSS_CYC(LOSS_CYC), .TICK_CYC(TICK_CYC)
) u_asserts (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .slowClk(slowClk), .slowTick(slowTick),
  .slowClockLost(slowClockLost), .irq(irq)
);

// ### tb/tb_cme_event_regs.sv
/* Bench for cme_event_regs: APB registers, events, slow clock loss.
   Assumes the short loss and tick counts set below. */
`timescale 1ns/1ps
module tb_cme_event_regs;
  localparam [31:0] IDV = 32'h0BAD0001; // Arbitrary value
  localparam LC = 40;
  localparam TC = 200;
  localparam [31:0] ALL = 32'hFFFFFFFF;
  localparam [31:0] EV = 32'h0001CFE0; // Ignores slow-clock events
  reg clk, rstn, psel, penable, pwrite, slowClk, candClk, slowRun, rerr, cap1, cap2, cur;
  reg [2:0] ampState;
  reg [7:0] pl;
  reg [3:0] dv;
  reg [11:0] paddr;
  reg [31:0] pwdata, rdat;
  wire [31:0] prdata, fastOscCtl, fastXtalCtl, slowOscCtl, slowXtalCtl;
  wire pready, pslverr, slowTick, slowClockLost, irq;
  int errTotal, nTests, k;
  int pos[8] = '{11, 10, 9, 16, 8, 7, 6, 5};
  cme_event_regs #(.IDENT_VALUE(IDV), .LOSS_CYC(LC), .TICK_CYC(TC)) dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slowClk(slowClk), .candClk(candClk), .ampState(ampState),
    .cap1AtTarget(cap1), .cap2AtTarget(cap2), .currentAtTarget(cur),
    .periodOutOfRange(pl[0]), .qualified(pl[1]), .incrementStored(pl[2]),
    .gearingRestart(pl[3]), .converterDone(pl[4]), .adcPeakDone(pl[5]),
    .adcBiasDone(pl[6]), .adcCompareDone(pl[7]), .slowTick(slowTick),
    .slowClockLost(slowClockLost), .irq(irq), .fastOscCtl(fastOscCtl),
    .fastXtalCtl(fastXtalCtl), .slowOscCtl(slowOscCtl), .slowXtalCtl(slowXtalCtl)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slow clock of 20 cycles per period; stands still when stopped
  always @(posedge clk) begin
    dv <= (dv == 4'h9) ? 4'h0 : dv + 4'h1;
    if (slowRun && dv == 4'h9) slowClk <= ~slowClk;
  end
  task closeOut;
    begin
      $display("comparisons %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      nTests++;
      if (g !== e) begin
        errTotal++;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tmo(input int lim);
    if (k >= lim) begin
      errTotal++;
      $display("[FAIL] wait exp %0d got %0d", lim, k);
      closeOut;
    end
  endtask
  // Setup, then access held until pready is sampled high
  task acc(input w, input [11:0] a, input [31:0] d);
    begin
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 16) begin
        @(posedge clk);
        k++;
      end
      tmo(16);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] e, input [31:0] m);
    begin
      acc(1'b0, a, 32'h0);
      chk(nm, e, rdat & m);
    end
  endtask
  task t_regs;
    begin
      rdc("ident", 12'h000, IDV, ALL);
      rdc("raw", 12'h048, 32'h0, EV);
      rdc("masked", 12'h04C, 32'h0, ALL);
      acc(1'b1, 12'h080, 32'hA5A5005A);
      rdc("ctl", 12'h080, 32'hA5A5005A, ALL);
      chk("ctl out", 32'hA5A5005A, fastOscCtl);
      // Distinct patterns per control word so a swapped decode shows up
      acc(1'b1, 12'h084, 32'h0000C3C3);
      acc(1'b1, 12'h08C, 32'h5A000001);
      acc(1'b1, 12'h090, 32'h80000080);
      rdc("xt ctl", 12'h084, 32'h0000C3C3, ALL);
      rdc("sosc ctl", 12'h08C, 32'h5A000001, ALL);
      rdc("sxt ctl", 12'h090, 32'h80000080, ALL);
      chk("xt out", 32'h0000C3C3, fastXtalCtl);
      chk("sosc out", 32'h5A000001, slowOscCtl);
      chk("sxt out", 32'h80000080, slowXtalCtl);
      acc(1'b1, 12'h000, ALL);
      rdc("ident ro", 12'h000, IDV, ALL);
      rdc("unmapped", 12'h060, 32'h0, ALL);
      chk("slverr", 32'h1, 32'(rerr));
      acc(1'b1, 12'h058, ALL);
      rdc("mset", 12'h044, 32'h0003FFE0, ALL);
      acc(1'b1, 12'h05C, 32'h00000FE0);
      acc(1'b1, 12'h058, 32'h0);
      rdc("mclr", 12'h044, 32'h0003F000, ALL);
      acc(1'b1, 12'h044, 32'h0);
      $display("register test done");
    end
  endtask
  task t_ev;
    bit [31:0] mk;
    begin
      mk = 32'h00010F00;
      acc(1'b1, 12'h058, mk);
      for (int i = 0; i < 8; i++) begin
        pl <= 8'h01 << i;
        @(posedge clk) pl <= 8'h00;
        @(posedge clk);
        rdc("raw ev", 12'h048, 32'h1 << pos[i], EV);
        rdc("mis ev", 12'h04C, mk & (32'h1 << pos[i]), EV);
        chk("irq", 32'(mk[pos[i]]), 32'(irq));
        acc(1'b1, 12'h054, 32'h0);
        rdc("clr 0", 12'h048, 32'h1 << pos[i], EV);
        acc(1'b1, 12'h054, 32'h1 << pos[i]);
        rdc("clr 1", 12'h048, 32'h0, EV);
      end
      acc(1'b1, 12'h050, ALL);
      rdc("force", 12'h048, 32'h0003FFE0, ALL);
      rdc("force mis", 12'h04C, mk, ALL);
      chk("irq set", 32'h1, 32'(irq));
      acc(1'b1, 12'h054, ALL);
      rdc("clr all", 12'h04C, 32'h0, ALL);
      chk("irq clr", 32'h0, 32'(irq));
      acc(1'b1, 12'h05C, ALL);
      $display("event test done");
    end
  endtask
  task t_amp;
    bit [2:0] am[4];
    bit [2:0] tg[4];
    bit [31:0] ae[4];
    begin
      am = '{3'h4, 3'h3, 3'h5, 3'h4};
      tg = '{3'h7, 3'h7, 3'h7, 3'h5};
      ae = '{32'h0000C000, 32'h00004000, 32'h0000C000, 32'h0};
      for (int i = 0; i < 4; i++) begin
        ampState <= am[i];
        {cap1, cap2, cur} <= tg[i];
        repeat (2) @(posedge clk);
        ampState <= 3'h0;
        {cap1, cap2, cur} <= 3'h0;
        @(posedge clk);
        rdc("amp", 12'h048, ae[i], 32'h0000C000);
        acc(1'b1, 12'h054, 32'h0000C000);
      end
      $display("amplitude test done");
    end
  endtask
  task t_slow;
    begin
      candClk <= 1'b1;
      repeat (3) @(posedge clk);
      candClk <= 1'b0;
      rdc("cand", 12'h048, 32'h00002000, 32'h00002000);
      acc(1'b1, 12'h054, 32'h00020000);
      k = 0;
      while (slowTick !== 1'b1 && k < 40) begin
        @(posedge clk);
        k++;
      end
      tmo(40);
      rdc("tick", 12'h048, 32'h00020000, 32'h00020000);
      slowRun <= 1'b0;
      k = 0;
      while (slowClockLost !== 1'b1 && k < LC + 30) begin
        @(posedge clk);
        k++;
      end
      tmo(LC + 30);
      rdc("loss", 12'h048, 32'h00001000, 32'h00001000);
      acc(1'b1, 12'h054, 32'h00020000);
      repeat (TC + 4) @(posedge clk);
      rdc("fallback", 12'h048, 32'h00020000, 32'h00020000);
      rdc("kept", 12'h080, 32'hA5A5005A, ALL);
      slowRun <= 1'b1;
      repeat (30) @(posedge clk);
      chk("regain", 32'h0, 32'(slowClockLost));
      $display("slow clock test done");
    end
  endtask
  initial begin
    {rstn, psel, penable, pwrite, slowClk, candClk, cap1, cap2, cur} = 9'h000;
    slowRun = 1'b1;
    ampState = 3'h0;
    pl = 8'h00;
    dv = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errTotal = 0;
    nTests = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_ev;
    t_amp;
    t_slow;
    closeOut;
  end
endmodule
